// >>> rtl/dac_trig_pkg.sv
package dac_trig_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ = 100_000_000;
    localparam int unsigned TICK_HZ = 1_000_000;
    localparam int unsigned TICK_DIV = SYS_CLK_HZ / TICK_HZ;
    localparam int unsigned TICK_CNT_W = 7;
    localparam logic [TICK_CNT_W-1:0] TICK_LAST =
        TICK_CNT_W'(TICK_DIV - 1);

    // ----------------------------------------------------------------
    // data widths
    // ----------------------------------------------------------------
    localparam int unsigned CODE_W = 12;
    localparam int unsigned CHAN_N = 4;
    localparam int unsigned CHAN_W = 2;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 16;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CODE0 = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CODE1 = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CODE2 = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CODE3 = 4'h3;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] REG_CNT_LOAD = 4'h6;
    localparam logic [ADDR_W-1:0] REG_CNT_VAL = 4'h7;
    localparam logic [ADDR_W-1:0] REG_CONV_CNT = 4'h8;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CTRL_MODE_LSB = 0;
    localparam int unsigned CTRL_PACE_EN = 2;
    localparam int unsigned CTRL_CNT_EXT = 3;
    localparam int unsigned CTRL_BUF_CLK = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

    // conversion start modes
    localparam logic [1:0] MODE_SOFT = 2'h0;
    localparam logic [1:0] MODE_EXT = 2'h1;
    localparam logic [1:0] MODE_BUF = 2'h2;

    // status fields
    localparam int unsigned STAT_GATE = 0;
    localparam int unsigned STAT_CLK = 1;
    localparam int unsigned STAT_KEEP = 2;
    localparam int unsigned STAT_PACE = 3;

    localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

endpackage

// >>> rtl/edge_sync.sv
`timescale 1ns/10ps
`default_nettype none

module edge_sync
    import dac_trig_pkg::*;
(
    input wire logic sys_clk,    // system clock
    input wire logic reset_n,    // sync reset
    input wire logic async_in,   // pin from outside
    output logic level_out,      // synchronised level
    output logic rise_out        // one-cycle rising pulse
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    // ----------------------------------------------------------------
    // two-stage synchroniser and edge detect
    // ----------------------------------------------------------------
    // first stage feeds only the second stage
    always_comb
    begin
        meta_d = async_in;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level_out = sync_q;
    assign rise_out = sync_q & ~prev_q;

endmodule

`default_nettype wire

// >>> rtl/dac_trigger_reset_control.sv
// Overview of operation
// - retention jumper picks keep or clear of output codes on bus reset
// - power-up always starts every output code at zero
// - software picks counter clock: external pin or internal 1 MHz
// - pacing output pulses once per buffer clock while enabled
// - in buffer mode each pacing rising edge starts one conversion
// - trigger gate high passes trigger edges, low blocks them
// - in external mode each gated rising trigger clock edge starts one conversion
`timescale 1ns/10ps
`default_nettype none

module dac_trigger_reset_control
    import dac_trig_pkg::*;
#(
    parameter int unsigned CODE_WIDTH = CODE_W  // converter code width
)
(
    input wire logic sys_clk,                       // 100 MHz clock
    input wire logic reset_n,                       // bus reset, sync low
    input wire logic power_on_reset_n,              // power-up reset, low
    input wire logic output_reset_retention_jumper, // 1 keeps codes
    input wire logic [ADDR_W-1:0] reg_addr,         // register address
    input wire logic [DATA_W-1:0] reg_wdata,        // write data
    input wire logic reg_wr,                        // write strobe
    input wire logic reg_rd,                        // read strobe
    output logic [DATA_W-1:0] reg_rdata,            // read data, next cycle
    input wire logic trigger_gate_input,            // trigger gate pin
    input wire logic trigger_clock_input,           // trigger clock pin
    input wire logic counter_zero_clock_input,      // counter clock pin
    input wire logic counter_zero_gate_input,       // counter gate pin
    output logic counter_zero_output,               // counter terminal out
    output logic buffer_pace_output,                // pacing pulse pin
    output logic conv_start,                        // one-cycle start
    output logic [CODE_WIDTH-1:0] code0,            // channel 0 code
    output logic [CODE_WIDTH-1:0] code1,            // channel 1 code
    output logic [CODE_WIDTH-1:0] code2,            // channel 2 code
    output logic [CODE_WIDTH-1:0] code3             // channel 3 code
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PACE_IDLE = 3'b001,
        PACE_HIGH = 3'b010,
        PACE_LOW  = 3'b100
    } pace_state_t;

    logic [CODE_WIDTH-1:0] code_q [CHAN_N];
    logic [CODE_WIDTH-1:0] code_d [CHAN_N];
    logic [CTRL_W-1:0] ctrl_q;
    logic [CTRL_W-1:0] ctrl_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic jumper_meta_q;
    logic jumper_meta_d;
    logic jumper_q;
    logic jumper_d;
    logic [TICK_CNT_W-1:0] tick_cnt_q;
    logic [TICK_CNT_W-1:0] tick_cnt_d;
    logic tick_q;
    logic tick_d;
    logic [CNT_W-1:0] cnt_load_q;
    logic [CNT_W-1:0] cnt_load_d;
    logic [CNT_W-1:0] cnt_val_q;
    logic [CNT_W-1:0] cnt_val_d;
    logic cnt_out_q;
    logic cnt_out_d;
    pace_state_t pace_q;
    pace_state_t pace_d;
    logic pace_out_q;
    logic pace_out_d;
    logic start_q;
    logic start_d;
    logic [DATA_W-1:0] conv_cnt_q;
    logic [DATA_W-1:0] conv_cnt_d;

    logic gate_lvl;
    logic trig_lvl;
    logic trig_rise;
    logic cclk_rise;
    logic cgate_lvl;
    logic pace_rise;
    logic cnt_tick;
    logic [1:0] mode;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    edge_sync u_gate_sync (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .async_in  (trigger_gate_input),
        .level_out (gate_lvl),
        .rise_out  ()
    );

    edge_sync u_trig_sync (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .async_in  (trigger_clock_input),
        .level_out (trig_lvl),
        .rise_out  (trig_rise)
    );

    edge_sync u_cclk_sync (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .async_in  (counter_zero_clock_input),
        .level_out (),
        .rise_out  (cclk_rise)
    );

    edge_sync u_cgate_sync (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .async_in  (counter_zero_gate_input),
        .level_out (cgate_lvl),
        .rise_out  ()
    );

    assign mode = ctrl_q[CTRL_MODE_LSB +: 2];

    // ----------------------------------------------------------------
    // register bus and output codes
    // ----------------------------------------------------------------
    // the jumper is a strap: two flops since it is a pin, and its
    // value under reset picks whether the codes survive a bus reset
    always_comb
    begin
        jumper_meta_d = output_reset_retention_jumper;
        jumper_d = jumper_meta_q;
        ctrl_d = ctrl_q;
        cnt_load_d = cnt_load_q;
        for (int i = 0; i < CHAN_N; i++)
        begin
            code_d[i] = code_q[i];
        end
        if (reg_wr)
        begin
            if (reg_addr <= REG_CODE3)
            begin
                code_d[reg_addr[CHAN_W-1:0]] = reg_wdata[CODE_WIDTH-1:0];
            end
            if (reg_addr == REG_CTRL)
            begin
                ctrl_d = reg_wdata[CTRL_W-1:0];
            end
            if (reg_addr == REG_CNT_LOAD)
            begin
                cnt_load_d = reg_wdata[CNT_W-1:0];
            end
        end
        rdata_d = DATA_ZERO;
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_CODE0, REG_CODE1, REG_CODE2, REG_CODE3:
                    rdata_d = DATA_W'(code_q[reg_addr[CHAN_W-1:0]]);
                REG_CTRL:
                    rdata_d = DATA_W'(ctrl_q);
                REG_STATUS:
                begin
                    rdata_d[STAT_GATE] = gate_lvl;
                    rdata_d[STAT_CLK] = trig_lvl;
                    rdata_d[STAT_KEEP] = jumper_q;
                    rdata_d[STAT_PACE] = pace_out_q;
                end
                REG_CNT_LOAD:
                    rdata_d = cnt_load_q;
                REG_CNT_VAL:
                    rdata_d = cnt_val_q;
                REG_CONV_CNT:
                    rdata_d = conv_cnt_q;
                default:
                    rdata_d = DATA_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        jumper_meta_q <= jumper_meta_d;
        jumper_q <= jumper_d;
        if (!power_on_reset_n)
        begin
            for (int i = 0; i < CHAN_N; i++)
            begin
                code_q[i] <= CODE_ZERO;
            end
        end
        else if (!reset_n)
        begin
            for (int i = 0; i < CHAN_N; i++)
            begin
                if (!jumper_q)
                begin
                    code_q[i] <= CODE_ZERO;
                end
            end
        end
        else
        begin
            for (int i = 0; i < CHAN_N; i++)
            begin
                code_q[i] <= code_d[i];
            end
        end
        if (!reset_n || !power_on_reset_n)
        begin
            ctrl_q <= CTRL_RESET;
            cnt_load_q <= {CNT_W{1'b0}};
            rdata_q <= DATA_ZERO;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            cnt_load_q <= cnt_load_d;
            rdata_q <= rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // counter zero with clock select
    // ----------------------------------------------------------------
    // the external clock is sampled at 100 MHz, so it is only honoured
    // up to 10 MHz where each high and low lasts several cycles
    assign cnt_tick = ctrl_q[CTRL_CNT_EXT] ? cclk_rise : tick_q;

    always_comb
    begin
        tick_d = 1'b0;
        tick_cnt_d = tick_cnt_q + TICK_CNT_W'(1);
        if (tick_cnt_q == TICK_LAST)
        begin
            tick_cnt_d = {TICK_CNT_W{1'b0}};
            tick_d = 1'b1;
        end
        cnt_val_d = cnt_val_q;
        cnt_out_d = cnt_out_q;
        if (reg_wr && reg_addr == REG_CNT_LOAD)
        begin
            cnt_val_d = reg_wdata[CNT_W-1:0];
            cnt_out_d = 1'b0;
        end
        else if (cnt_tick && cgate_lvl)
        begin
            if (cnt_val_q == {CNT_W{1'b0}})
            begin
                cnt_val_d = cnt_load_q;
                cnt_out_d = ~cnt_out_q;
            end
            else
            begin
                cnt_val_d = cnt_val_q - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !power_on_reset_n)
        begin
            tick_cnt_q <= {TICK_CNT_W{1'b0}};
            tick_q <= 1'b0;
            cnt_val_q <= {CNT_W{1'b0}};
            cnt_out_q <= 1'b0;
        end
        else
        begin
            tick_cnt_q <= tick_cnt_d;
            tick_q <= tick_d;
            cnt_val_q <= cnt_val_d;
            cnt_out_q <= cnt_out_d;
        end
    end

    // ----------------------------------------------------------------
    // buffer pacing pulse and conversion start
    // ----------------------------------------------------------------
    // each buffer clock gives one high cycle, then two low cycles so that
    // back-to-back buffer clocks still show distinct edges
    assign pace_rise = (pace_q == PACE_HIGH);

    always_comb
    begin
        pace_d = pace_q;
        pace_out_d = 1'b0;
        unique case (pace_q)
            PACE_IDLE:
                if (ctrl_q[CTRL_PACE_EN] && ctrl_q[CTRL_BUF_CLK])
                begin
                    pace_d = PACE_HIGH;
                end
            PACE_HIGH:
                pace_d = PACE_LOW;
            PACE_LOW:
                pace_d = PACE_IDLE;
            default:
                pace_d = PACE_IDLE;
        endcase
        if (pace_d == PACE_HIGH)
        begin
            pace_out_d = 1'b1;
        end
        start_d = 1'b0;
        if (mode == MODE_EXT && trig_rise && gate_lvl)
        begin
            start_d = 1'b1;
        end
        if (mode == MODE_BUF && pace_rise)
        begin
            start_d = 1'b1;
        end
        if (mode == MODE_SOFT && reg_wr && reg_addr <= REG_CODE3)
        begin
            start_d = 1'b1;
        end
        conv_cnt_d = conv_cnt_q + DATA_W'(start_q);
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n || !power_on_reset_n)
        begin
            pace_q <= PACE_IDLE;
            pace_out_q <= 1'b0;
            start_q <= 1'b0;
            conv_cnt_q <= DATA_ZERO;
        end
        else
        begin
            pace_q <= pace_d;
            pace_out_q <= pace_out_d;
            start_q <= start_d;
            conv_cnt_q <= conv_cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign counter_zero_output = cnt_out_q;
    assign buffer_pace_output = pace_out_q;
    assign conv_start = start_q;
    assign code0 = code_q[0];
    assign code1 = code_q[1];
    assign code2 = code_q[2];
    assign code3 = code_q[3];

endmodule

`default_nettype wire

// >>> sim/dac_trig_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module dac_trig_chk
    import dac_trig_pkg::*;
#(
    parameter int unsigned CODE_WIDTH = CODE_W // code width
)
(
    input wire logic sys_clk, // clock
    input wire logic reset_n, // bus reset
    input wire logic power_on_reset_n, // power reset
    input wire logic output_reset_retention_jumper, // strap
    input wire logic [ADDR_W-1:0] reg_addr, // address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // read data
    input wire logic trigger_gate_input, // gate pin
    input wire logic trigger_clock_input, // trigger pin
    input wire logic buffer_pace_output, // pace pin
    input wire logic conv_start, // start pulse
    input wire logic [CODE_WIDTH-1:0] code0, // code 0
    input wire logic [CODE_WIDTH-1:0] code1, // code 1
    input wire logic [CODE_WIDTH-1:0] code2, // code 2
    input wire logic [CODE_WIDTH-1:0] code3 // code 3
);
    // ----------------------------------------
    // mode and pace enable as the host set them
    // ----------------------------------------
    logic [1:0] mode_d, mode_q;
    logic pace_d, pace_q;
    logic run, zero, jmp;
    assign run = reset_n & power_on_reset_n;
    assign zero = ~|{code0, code1, code2, code3};
    assign jmp = output_reset_retention_jumper;

    // either reset clears control, as in the device
    always_comb
    begin
        mode_d = mode_q;
        pace_d = pace_q;
        if (!run)
        begin
            mode_d = MODE_SOFT;
            pace_d = 1'b0;
        end
        else if (reg_wr && reg_addr == REG_CTRL)
        begin
            mode_d = reg_wdata[1:0];
            pace_d = reg_wdata[CTRL_PACE_EN];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        mode_q <= mode_d;
        pace_q <= pace_d;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!run);

    a_power_clear:
    assert property (disable iff (!reset_n) !power_on_reset_n |=> zero)
        else $error("codes not zero after power reset");
    a_bus_clear:
    assert property (disable iff (!power_on_reset_n)
        !reset_n && !jmp && !$past(jmp) && !$past(jmp, 2) |=> zero)
        else $error("codes kept over bus reset with strap off");
    a_bus_keep:
    assert property (disable iff (!power_on_reset_n)
        !reset_n && jmp && $past(jmp) && $past(jmp, 2)
        |=> $stable(code0) && $stable(code1)
        && $stable(code2) && $stable(code3))
        else $error("codes lost over bus reset with strap on");
    a_ext_start:
    assert property (mode_q == MODE_EXT && $past(mode_q) == MODE_EXT
        && trigger_gate_input && $past(trigger_gate_input, 3)
        && $rose(trigger_clock_input) |-> ##[2:4] conv_start)
        else $error("gated trigger edge gave no start");
    a_gate_block:
    assert property (mode_q == MODE_EXT && !trigger_gate_input
        && !$past(trigger_gate_input, 3) && $rose(trigger_clock_input)
        |=> !conv_start [*6])
        else $error("start while gate low");
    a_ext_single:
    assert property (mode_q == MODE_EXT && $past(mode_q) == MODE_EXT
        && conv_start |=> !conv_start)
        else $error("one trigger edge gave two starts");
    a_buf_start:
    assert property (mode_q == MODE_BUF && $past(mode_q) == MODE_BUF
        && $rose(buffer_pace_output) |=> conv_start)
        else $error("pace edge without start");
    a_pace_pulse:
    assert property (buffer_pace_output |=> !buffer_pace_output)
        else $error("pace pulse longer than a cycle");
    a_pace_off:
    assert property (!pace_q && !$past(pace_q) |-> !buffer_pace_output)
        else $error("pace pulse while disabled");
endmodule

bind dac_trigger_reset_control dac_trig_chk #(.CODE_WIDTH(CODE_WIDTH))
    dac_trig_chk_i (.sys_clk, .reset_n, .power_on_reset_n,
    .output_reset_retention_jumper, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .trigger_gate_input, .trigger_clock_input,
    .buffer_pace_output, .conv_start, .code0, .code1, .code2, .code3);

`default_nettype wire

// >>> sim/trig_source.sv
`timescale 1ns/10ps
`default_nettype none

module trig_source
(
    input wire logic clk, // system clock
    output logic gate, // trigger gate level
    output logic trig, // trigger clock
    output logic cclk // counter clock
);
    // ----------------------------------------
    // outside trigger equipment
    // ----------------------------------------
    // pins at a defined level from time zero
    initial
    begin
        gate = 1'b0;
        trig = 1'b0;
        cclk = 1'b0;
    end

    // gate is a level, settled well before any edge
    task automatic set_gate(input logic v);
        gate <= v;
        repeat (4) @(posedge clk);
    endtask

    // hold 2 is the fastest the device takes; 5 keeps cclk at 10 MHz
    task automatic pulses(input int n, input int hold, input logic cnt);
        for (int i = 0; i < n; i++)
        begin
            if (cnt)
                cclk <= 1'b1;
            else
                trig <= 1'b1;
            repeat (hold) @(posedge clk);
            cclk <= 1'b0;
            trig <= 1'b0;
            repeat (hold) @(posedge clk);
        end
    endtask
endmodule

`default_nettype wire

// >>> sim/dac_trigger_reset_control_bench.sv
`timescale 1ns/10ps
`default_nettype none

module dac_trigger_reset_control_bench
    import dac_trig_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic por_n = 1'b0;
    logic jumper = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata, v;
    logic gate, trig, cclk, pace, conv, cnt_out;
    logic [CODE_W-1:0] code [4];
    int n_errors = 0;
    int n_tests = 0;
    int n_conv = 0;
    int n_pace = 0;
    int c0, p0;

    // ----------------------------------------
    // clock, partner and device
    // ----------------------------------------
    always #5 sys_clk = ~sys_clk;

    trig_source trig_source_i (.clk(sys_clk), .gate(gate), .trig(trig),
        .cclk(cclk));

    // counter gate held open so every counter edge counts
    dac_trigger_reset_control dac_trigger_reset_control_i (.sys_clk,
        .reset_n, .power_on_reset_n(por_n),
        .output_reset_retention_jumper(jumper), .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .trigger_gate_input(gate),
        .trigger_clock_input(trig), .counter_zero_clock_input(cclk),
        .counter_zero_gate_input(1'b1), .counter_zero_output(cnt_out),
        .buffer_pace_output(pace), .conv_start(conv), .code0(code[0]),
        .code1(code[1]), .code2(code[2]), .code3(code[3]));

    // non-blocking so reads at an edge never race the count
    always @(posedge sys_clk)
    begin
        if (conv === 1'b1)
            n_conv <= n_conv + 1;
        if (pace === 1'b1)
            n_pace <= n_pace + 1;
    end

    task automatic check(input logic [DATA_W-1:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        // taken mid-cycle, clear of the edge that drops the data
        @(negedge sys_clk);
        d = reg_rdata;
        @(posedge sys_clk);
    endtask

    task automatic chk_reg(input logic [ADDR_W-1:0] a, logic [15:0] e);
        rd(a, v);
        check(v, e);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic hit_reset(input logic power);
        if (power)
            por_n <= 1'b0;
        else
            reset_n <= 1'b0;
        cyc(4);
        por_n <= 1'b1;
        reset_n <= 1'b1;
        cyc(1);
    endtask

    task automatic tally_and_finish;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial
    begin
        cyc(3);
        reset_n <= 1'b1;
        por_n <= 1'b1;
        cyc(1);
        for (int i = 0; i < 4; i++)
            wr(ADDR_W'(i), 16'h0a50 + DATA_W'(i));
        hit_reset(1'b0);
        for (int i = 0; i < 4; i++)
            chk_reg(ADDR_W'(i), 16'h0a50 + DATA_W'(i));
        check(DATA_W'(code[3]), 16'h0a53);
        chk_reg(4'hf, DATA_ZERO);
        // strap off: a bus reset clears every code
        jumper <= 1'b0;
        cyc(2);
        hit_reset(1'b0);
        for (int i = 0; i < 4; i++)
            check(DATA_W'(code[i]), DATA_ZERO);
        // power loss clears codes even with the strap fitted
        jumper <= 1'b1;
        wr(REG_CODE1, 16'h0fff);
        cyc(2);
        hit_reset(1'b1);
        check(DATA_W'(code[1]), DATA_ZERO);
        chk_reg(REG_CODE1, DATA_ZERO);
        // trigger edges: dropped with gate low, counted, fast and slow
        wr(REG_CTRL, DATA_W'(MODE_EXT));
        c0 = n_conv;
        trig_source_i.pulses(3, 2, 1'b0);
        cyc(4);
        check(DATA_W'(n_conv - c0), DATA_ZERO);
        trig_source_i.set_gate(1'b1);
        chk_reg(REG_STATUS, 16'h0005);
        trig_source_i.pulses(5, 2, 1'b0);
        trig_source_i.pulses(2, 9, 1'b0);
        cyc(4);
        check(DATA_W'(n_conv - c0), 16'h0007);
        chk_reg(REG_CONV_CNT, 16'h0007);
        // buffer pacing: one start per pace pulse, none when disabled
        c0 = n_conv;
        p0 = n_pace;
        wr(REG_CTRL, 16'h0016);
        cyc(30);
        wr(REG_CTRL, DATA_ZERO);
        cyc(4);
        check(DATA_W'(n_conv - c0), DATA_W'(n_pace - p0));
        check(DATA_W'(n_pace - p0 > 4), 16'h0001);
        p0 = n_pace;
        wr(REG_CTRL, 16'h0012);
        cyc(30);
        check(DATA_W'(n_pace - p0), DATA_ZERO);
        // counter clock from the pin, then from the internal tick
        wr(REG_CTRL, 16'h0008);
        wr(REG_CNT_LOAD, 16'h0010);
        cyc(250);
        chk_reg(REG_CNT_VAL, 16'h0010);
        trig_source_i.pulses(4, 5, 1'b1);
        cyc(4);
        chk_reg(REG_CNT_VAL, 16'h000c);
        wr(REG_CTRL, DATA_ZERO);
        cyc(250);
        rd(REG_CNT_VAL, v);
        check(DATA_W'(v < 16'h000c), 16'h0001);
        // reload from zero on the pin clock toggles the counter output
        wr(REG_CTRL, 16'h0008);
        wr(REG_CNT_LOAD, 16'h0001);
        trig_source_i.pulses(2, 5, 1'b1);
        cyc(4);
        check(DATA_W'(cnt_out), 16'h0001);
        tally_and_finish();
    end

    // a hang counts as a mismatch
    initial
    begin
        cyc(5000);
        n_errors++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
